/* File: logic/uart_pin_pkg.sv */
package uart_pin_pkg;

	// Register byte addresses on the AXI4-Lite port
	localparam logic [7:0] ADDR_TXDATA = 8'h00;
	localparam logic [7:0] ADDR_FIFOCTL = 8'h04;
	localparam logic [7:0] ADDR_LINECTL = 8'h08;
	localparam logic [7:0] ADDR_MODEMCTL = 8'h0C;
	localparam logic [7:0] ADDR_ADDCTL = 8'h10;
	localparam logic [7:0] ADDR_CLKSEL = 8'h14;
	localparam logic [7:0] ADDR_CTRL = 8'h18;
	localparam logic [7:0] ADDR_THRESH = 8'h1C;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	localparam logic [7:0] ADDR_BAUD = 8'h24;

	// Field positions
	localparam int FIFOCTL_DEEP_BIT = 5;
	localparam int LINECTL_EXT_BIT = 7;
	localparam int MODEMCTL_DTR_BIT = 0;
	localparam int MODEMCTL_IRDA_BIT = 6;
	localparam int ADDCTL_485_LSB = 3;
	localparam int CLKSEL_TXCLK_LSB = 4;
	localparam int CTRL_ENH_BIT = 0;
	localparam int CTRL_FLOW_BIT = 1;
	localparam int ST_STRAP_BIT = 0;
	localparam int ST_DEEP_BIT = 1;
	localparam int ST_TXEMPTY_BIT = 2;
	localparam int ST_DTR_BIT = 3;

	// Field encodings
	localparam logic [1:0] ADDCTL_485_TRUE = 2'h2;
	localparam logic [1:0] ADDCTL_485_INV = 2'h3;
	localparam logic [1:0] CLKSEL_TXCLK_1X = 2'h1;
	localparam logic [1:0] CLKSEL_TXCLK_NX = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// FIFO depths reported to the channel FIFOs
	localparam logic [7:0] DEPTH_LEGACY = 8'h10;
	localparam logic [7:0] DEPTH_DEEP = 8'h80;

	// Reset values
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [7:0] UPPER_RST = 8'h0C;
	localparam logic [7:0] LOWER_RST = 8'h04;
	localparam logic [15:0] BAUD_RST = 16'h0001;

	// Bit timing: sixteen ticks per bit, IrDA pulse lasts three ticks
	localparam logic [3:0] SUB_LAST = 4'hF;
	localparam logic [3:0] SUB_HALF = 4'h8;
	localparam logic [3:0] IRDA_PULSE = 4'h3;
	localparam logic [3:0] BIT_LAST = 4'h9;
	localparam logic [4:0] RX_HOLD = 5'h10;

	typedef enum logic [1:0] {DTR_PLAIN, DTR_FLOW, DTR_485, DTR_CLK} dtr_mode_t;

endpackage : uart_pin_pkg

/* File: logic/stream_if.sv */
`timescale 1ns/1ps
`default_nettype none

// Valid/ready byte stream between the register port and the transmitter
interface stream_if #(parameter int W = 8);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface : stream_if

`default_nettype wire

/* File: logic/fifo_buf.sv */
`timescale 1ns/1ps
`default_nettype none

module fifo_buf #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	stream_if.snk in_s,
	stream_if.src out_s
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
	logic [CW-1:0] count_q, count_d;
	logic push, pop;

	// Full and empty come straight from the count, so ready is honest
	assign in_s.ready = (count_q != CW'(DEPTH));
	assign out_s.valid = (count_q != '0);
	assign out_s.data = mem_q[rptr_q];
	assign push = in_s.valid && in_s.ready;
	assign pop = out_s.valid && out_s.ready;

	// Pointer and count update
	always_comb begin
		wptr_d = wptr_q;
		rptr_d = rptr_q;
		if (push) begin
			wptr_d = (wptr_q == PW'(DEPTH - 1)) ? '0 : wptr_q + 1'b1;
		end
		if (pop) begin
			rptr_d = (rptr_q == PW'(DEPTH - 1)) ? '0 : rptr_q + 1'b1;
		end
		count_d = count_q + CW'(push) - CW'(pop);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wptr_q <= '0;
			rptr_q <= '0;
			count_q <= '0;
		end else begin
			wptr_q <= wptr_d;
			rptr_q <= rptr_d;
			count_q <= count_d;
		end
	end

	// Storage needs no reset; reads are gated by valid
	always_ff @(posedge aclk) begin
		if (push) begin
			mem_q[wptr_q] <= in_s.data;
		end
	end

endmodule : fifo_buf

`default_nettype wire

/* File: logic/uart_pin_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

module uart_pin_ctrl import uart_pin_pkg::*; #(
	parameter int FIFO_WORDS = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic fifo_depth_strap,
	input wire logic serial_data_in,
	input wire logic [7:0] rx_fill_level,
	output logic serial_data_out,
	output logic term_ready_n,
	output logic rx_serial,
	output logic [7:0] fifo_depth
);
	typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;

	stream_if #(.W(8)) tx_in();
	stream_if #(.W(8)) tx_out();

	logic aw_held_q, aw_held_d, w_held_q, w_held_d;
	logic [7:0] aw_addr_q, aw_addr_d;
	logic [31:0] w_data_q, w_data_d;
	logic [3:0] w_strb_q, w_strb_d;
	logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
	logic [1:0] bresp_d, rresp_d;
	logic [31:0] rdata_d;
	logic wr_fire, ar_fire;
	logic [7:0] fifoctl_q, fifoctl_d, linectl_q, linectl_d, modemctl_q, modemctl_d;
	logic [7:0] addctl_q, addctl_d;
	logic [7:0] clksel_q, clksel_d, ctrl_q, ctrl_d, upper_q, upper_d, lower_q, lower_d;
	logic [15:0] baud_q, baud_d;
	logic deep_sel_q, deep_sel_d;
	logic [1:0] sync1_q, sync2_q, sync3_q, stable_q, stable_d;
	logic strap_s, rx_s;
	tx_state_t tx_q, tx_d;
	logic [15:0] div_q, div_d;
	logic [3:0] sub_q, sub_d, bitn_q, bitn_d;
	logic [9:0] shreg_q, shreg_d;
	logic nx_clk_q, nx_clk_d, tick, tx_empty, bit_clk, irda_on;
	logic [4:0] hold_q, hold_d;
	logic flow_hold_q, flow_hold_d;
	dtr_mode_t mode;
	logic sdo_d, dtr_d, rxs_d;
	logic [7:0] depth_d;

	fifo_buf #(.WIDTH(8), .DEPTH(FIFO_WORDS)) u_tx_fifo (
		.aclk(aclk),
		.aresetn(aresetn),
		.in_s(tx_in),
		.out_s(tx_out)
	);

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave

	function automatic logic addr_known(input logic [7:0] a);
		return a inside {ADDR_TXDATA, ADDR_FIFOCTL, ADDR_LINECTL, ADDR_MODEMCTL, ADDR_ADDCTL,
			ADDR_CLKSEL, ADDR_CTRL, ADDR_THRESH, ADDR_STATUS, ADDR_BAUD};
	endfunction : addr_known

	// A data write stalls in the holding stage while the FIFO is full
	assign wr_fire = aw_held_q && w_held_q && !bvalid
		&& (aw_addr_q != ADDR_TXDATA || tx_in.ready);
	assign ar_fire = arvalid && arready;
	assign tx_in.valid = wr_fire && aw_addr_q == ADDR_TXDATA && w_strb_q[0];
	assign tx_in.data = w_data_q[7:0];

	// Address and data are held separately, so either may come first
	always_comb begin
		aw_held_d = aw_held_q;
		aw_addr_d = aw_addr_q;
		w_held_d = w_held_q;
		w_data_d = w_data_q;
		w_strb_d = w_strb_q;
		bvalid_d = bvalid;
		bresp_d = bresp;
		if (awvalid && awready) begin
			aw_held_d = 1'b1;
			aw_addr_d = awaddr;
		end
		if (wvalid && wready) begin
			w_held_d = 1'b1;
			w_data_d = wdata;
			w_strb_d = wstrb;
		end
		if (bvalid && bready) begin
			bvalid_d = 1'b0;
		end
		if (wr_fire) begin
			aw_held_d = 1'b0;
			w_held_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = addr_known(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
		end
		awready_d = !aw_held_d;
		wready_d = !w_held_d;
	end

	// Read answers one cycle after the address is taken
	always_comb begin
		rvalid_d = rvalid;
		rdata_d = rdata;
		rresp_d = rresp;
		if (rvalid && rready) begin
			rvalid_d = 1'b0;
		end
		if (ar_fire) begin
			rvalid_d = 1'b1;
			rresp_d = addr_known(araddr) ? RESP_OKAY : RESP_SLVERR;
			unique case (araddr)
				ADDR_FIFOCTL: rdata_d = {24'h000000, fifoctl_q};
				ADDR_LINECTL: rdata_d = {24'h000000, linectl_q};
				ADDR_MODEMCTL: rdata_d = {24'h000000, modemctl_q};
				ADDR_ADDCTL: rdata_d = {24'h000000, addctl_q};
				ADDR_CLKSEL: rdata_d = {24'h000000, clksel_q};
				ADDR_CTRL: rdata_d = {24'h000000, ctrl_q};
				ADDR_THRESH: rdata_d = {16'h0000, lower_q, upper_q};
				ADDR_BAUD: rdata_d = {16'h0000, baud_q};
				ADDR_STATUS: rdata_d = {28'h0000000, term_ready_n, tx_empty,
					fifo_depth == DEPTH_DEEP, strap_s};
				default: rdata_d = 32'h00000000;
			endcase
		end
		arready_d = !rvalid_d;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_held_q <= 1'b0;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= RESP_OKAY;
		end else begin
			aw_held_q <= aw_held_d;
			aw_addr_q <= aw_addr_d;
			w_held_q <= w_held_d;
			w_data_q <= w_data_d;
			w_strb_q <= w_strb_d;
			awready <= awready_d;
			wready <= wready_d;
			bvalid <= bvalid_d;
			bresp <= bresp_d;
			arready <= arready_d;
			rvalid <= rvalid_d;
			rdata <= rdata_d;
			rresp <= rresp_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control registers

	always_comb begin
		fifoctl_d = fifoctl_q;
		linectl_d = linectl_q;
		modemctl_d = modemctl_q;
		addctl_d = addctl_q;
		clksel_d = clksel_q;
		ctrl_d = ctrl_q;
		upper_d = upper_q;
		lower_d = lower_q;
		baud_d = baud_q;
		deep_sel_d = deep_sel_q;
		if (wr_fire && w_strb_q[0]) begin
			unique case (aw_addr_q)
				ADDR_FIFOCTL: begin
					fifoctl_d = w_data_q[7:0];
					if (linectl_q[LINECTL_EXT_BIT]) begin
						deep_sel_d = w_data_q[FIFOCTL_DEEP_BIT];
					end
				end
				ADDR_LINECTL: linectl_d = w_data_q[7:0];
				ADDR_MODEMCTL: modemctl_d = w_data_q[7:0];
				ADDR_ADDCTL: addctl_d = w_data_q[7:0];
				ADDR_CLKSEL: clksel_d = w_data_q[7:0];
				ADDR_CTRL: ctrl_d = w_data_q[7:0];
				ADDR_THRESH: upper_d = w_data_q[7:0];
				ADDR_BAUD: baud_d[7:0] = w_data_q[7:0];
				default: ;
			endcase
		end
		// Second byte lane only exists for the threshold and baud words
		if (wr_fire && w_strb_q[1] && aw_addr_q == ADDR_THRESH) begin
			lower_d = w_data_q[15:8];
		end
		if (wr_fire && w_strb_q[1] && aw_addr_q == ADDR_BAUD) begin
			baud_d[15:8] = w_data_q[15:8];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fifoctl_q <= REG_RST;
			linectl_q <= REG_RST;
			modemctl_q <= REG_RST;
			addctl_q <= REG_RST;
			clksel_q <= REG_RST;
			ctrl_q <= REG_RST;
			upper_q <= UPPER_RST;
			lower_q <= LOWER_RST;
			baud_q <= BAUD_RST;
			deep_sel_q <= 1'b0;
		end else begin
			fifoctl_q <= fifoctl_d;
			linectl_q <= linectl_d;
			modemctl_q <= modemctl_d;
			addctl_q <= addctl_d;
			clksel_q <= clksel_d;
			ctrl_q <= ctrl_d;
			upper_q <= upper_d;
			lower_q <= lower_d;
			baud_q <= baud_d;
			deep_sel_q <= deep_sel_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: a level counts once stages two and three agree

	assign strap_s = stable_q[0];
	assign rx_s = stable_q[1];

	always_comb begin
		stable_d = stable_q;
		for (int i = 0; i < 2; i++) begin
			if (sync2_q[i] == sync3_q[i]) begin
				stable_d[i] = sync3_q[i];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_q <= 2'h0;
			sync2_q <= 2'h0;
			sync3_q <= 2'h0;
			stable_q <= 2'h0;
		end else begin
			sync1_q <= {serial_data_in, fifo_depth_strap};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			stable_q <= stable_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transmitter: 8N1, sixteen baud ticks per bit

	assign tick = (div_q == 16'h0000);
	assign tx_out.ready = (tx_q == TX_IDLE);
	assign tx_empty = (tx_q == TX_IDLE) && !tx_out.valid;
	assign bit_clk = (tx_q == TX_SHIFT) && (sub_q < SUB_HALF);
	assign irda_on = ctrl_q[CTRL_ENH_BIT] && modemctl_q[MODEMCTL_IRDA_BIT];

	always_comb begin
		tx_d = tx_q;
		sub_d = sub_q;
		bitn_d = bitn_q;
		shreg_d = shreg_q;
		div_d = tick ? baud_q - 16'h0001 : div_q - 16'h0001;
		nx_clk_d = tick ? !nx_clk_q : nx_clk_q;
		unique case (tx_q)
			TX_IDLE: begin
				if (tx_out.valid) begin
					tx_d = TX_SHIFT;
					shreg_d = {1'b1, tx_out.data, 1'b0};
					sub_d = 4'h0;
					bitn_d = 4'h0;
				end
			end
			TX_SHIFT: begin
				if (tick) begin
					sub_d = sub_q + 4'h1;
					if (sub_q == SUB_LAST) begin
						shreg_d = {1'b1, shreg_q[9:1]};
						bitn_d = bitn_q + 4'h1;
						if (bitn_q == BIT_LAST) begin
							tx_d = TX_IDLE;
						end
					end
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_q <= TX_IDLE;
			div_q <= 16'h0000;
			sub_q <= 4'h0;
			bitn_q <= 4'h0;
			shreg_q <= 10'h3FF;
			nx_clk_q <= 1'b0;
		end else begin
			tx_q <= tx_d;
			div_q <= div_d;
			sub_q <= sub_d;
			bitn_q <= bitn_d;
			shreg_q <= shreg_d;
			nx_clk_q <= nx_clk_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin functions: depth, IrDA, terminal-ready

	// Clock output outranks RS485, which outranks flow control
	always_comb begin
		if (clksel_q[CLKSEL_TXCLK_LSB+:2] inside {CLKSEL_TXCLK_1X, CLKSEL_TXCLK_NX}) begin
			mode = DTR_CLK;
		end else if (addctl_q[ADDCTL_485_LSB+:2] inside {ADDCTL_485_TRUE, ADDCTL_485_INV}) begin
			mode = DTR_485;
		end else if (ctrl_q[CTRL_FLOW_BIT]) begin
			mode = DTR_FLOW;
		end else begin
			mode = DTR_PLAIN;
		end
	end

	always_comb begin
		depth_d = (strap_s || deep_sel_q || ctrl_q[CTRL_ENH_BIT]) ? DEPTH_DEEP
			: DEPTH_LEGACY;
		// Hysteresis: reaching upper wins over falling below lower
		flow_hold_d = flow_hold_q;
		if (rx_fill_level >= upper_q) begin
			flow_hold_d = 1'b1;
		end else if (rx_fill_level < lower_q) begin
			flow_hold_d = 1'b0;
		end
		unique case (mode)
			DTR_CLK: dtr_d = (clksel_q[CLKSEL_TXCLK_LSB+:2] == CLKSEL_TXCLK_NX) ? nx_clk_q
				: bit_clk;
			DTR_485: dtr_d = addctl_q[ADDCTL_485_LSB] ? !tx_empty : tx_empty;
			DTR_FLOW: dtr_d = !flow_hold_d;
			DTR_PLAIN: dtr_d = !modemctl_q[MODEMCTL_DTR_BIT];
		endcase
		// IrDA: a short high pulse marks each zero bit, idle stays low
		sdo_d = irda_on ? ((tx_q == TX_SHIFT) && !shreg_q[0] && sub_q < IRDA_PULSE)
			: shreg_q[0];
		// A received IrDA pulse becomes a zero held for one bit of ticks from its start;
		// reloading on every high cycle would stretch the zero by the pulse width
		hold_d = hold_q;
		if (irda_on && rx_s && hold_q == 5'h00) begin
			hold_d = RX_HOLD;
		end else if (tick && hold_q != 5'h00) begin
			hold_d = hold_q - 5'h01;
		end
		rxs_d = irda_on ? (hold_d == 5'h00) : rx_s;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fifo_depth <= DEPTH_LEGACY;
			flow_hold_q <= 1'b0;
			term_ready_n <= 1'b1;
			serial_data_out <= 1'b1;
			hold_q <= 5'h00;
			rx_serial <= 1'b1;
		end else begin
			fifo_depth <= depth_d;
			flow_hold_q <= flow_hold_d;
			term_ready_n <= dtr_d;
			serial_data_out <= sdo_d;
			hold_q <= hold_d;
			rx_serial <= rxs_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence deep_wr_s;
		wr_fire && aw_addr_q == ADDR_FIFOCTL && w_strb_q[0] && w_data_q[FIFOCTL_DEEP_BIT]
			&& linectl_q[LINECTL_EXT_BIT];
	endsequence

	depth_legacy_a: assert property (!strap_s && !deep_sel_q && !ctrl_q[CTRL_ENH_BIT] |=>
		fifo_depth == DEPTH_LEGACY) else $error("depth not legacy");
	depth_strap_a: assert property (strap_s |=> fifo_depth == DEPTH_DEEP)
		else $error("strap high but depth not deep");
	strap_read_a: assert property (ar_fire && araddr == ADDR_STATUS |=>
		rdata[ST_STRAP_BIT] == $past(strap_s)) else $error("status strap wrong");
	ctl_deep_a: assert property (deep_wr_s |=> ##1 fifo_depth == DEPTH_DEEP)
		else $error("fcr write did not deepen fifo");
	enh_deep_a: assert property (ctrl_q[CTRL_ENH_BIT] |=> fifo_depth == DEPTH_DEEP)
		else $error("enhanced mode not deep");
	irda_tx_a: assert property (irda_on && sub_q >= IRDA_PULSE |=> !serial_data_out)
		else $error("irda pulse too long");
	irda_rx_a: assert property (irda_on && rx_s && hold_q == 5'h00 |=> !rx_serial)
		else $error("irda pulse not decoded");
	flow_on_a: assert property (mode == DTR_FLOW && rx_fill_level >= upper_q |=> !term_ready_n)
		else $error("flow output not asserted");
	flow_off_a: assert property (mode == DTR_FLOW && rx_fill_level < lower_q
		&& rx_fill_level < upper_q |=> term_ready_n) else $error("flow not released");
	rs485_dir_a: assert property (mode == DTR_485 && addctl_q[ADDCTL_485_LSB] |=>
		term_ready_n == !$past(tx_empty)) else $error("rs485 direction wrong");
	tx_clk_a: assert property (mode == DTR_CLK
		&& clksel_q[CLKSEL_TXCLK_LSB+:2] == CLKSEL_TXCLK_1X |=>
		term_ready_n == $past(bit_clk)) else $error("tx clock not on pin");
	plain_dtr_a: assert property (mode == DTR_PLAIN |=>
		term_ready_n == !$past(modemctl_q[MODEMCTL_DTR_BIT])) else $error("plain dtr wrong");

endmodule : uart_pin_ctrl

`default_nettype wire

/* File: verif/line_partner.sv */
`timescale 1ns/1ps
`default_nettype none

// Line transceiver: decodes NRZ frames, counts IrDA pulses, drives the receive line
module line_partner #(
	parameter int BIT_CLKS = 32
) (
	input wire logic aclk,
	input wire logic serial_data_out,
	output logic serial_data_in
);
	logic [7:0] frames [$];
	int pulse_count = 0;
	logic nrz_on = 1'b1;
	logic prev_q = 1'b1;

	initial serial_data_in = 1'b1;

	// Count rising edges only, so one long high level counts once
	always @(posedge aclk) begin
		if (serial_data_out === 1'b1 && prev_q === 1'b0) pulse_count++;
		prev_q <= serial_data_out;
	end

	// NRZ decoder samples mid-bit; it is parked in IrDA mode where idle is low
	initial begin
		logic [7:0] b;
		forever begin
			@(negedge serial_data_out iff nrz_on);
			repeat (BIT_CLKS / 2) @(posedge aclk);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CLKS) @(posedge aclk);
				b[i] = serial_data_out;
			end
			repeat (BIT_CLKS) @(posedge aclk);
			frames.push_back(b);
		end
	end

	// Hold the receive line at one level for a number of clocks
	task drive_line(input logic v, input int clks);
		serial_data_in <= v;
		repeat (clks) @(posedge aclk);
	endtask : drive_line
endmodule : line_partner

`default_nettype wire

/* File: verif/test_uart_pin_function_control.sv */
`timescale 1ns/1ps
`default_nettype none

module test_uart_pin_function_control import uart_pin_pkg::*;;
	localparam int BAUD = 2;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic awvalid = 1'b0;
	logic awready;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic wvalid = 1'b0;
	logic wready;
	logic [1:0] bresp;
	logic bvalid;
	logic bready = 1'b0;
	logic [7:0] araddr = 8'h00;
	logic arvalid = 1'b0;
	logic arready;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic rvalid;
	logic rready = 1'b0;
	logic fifo_depth_strap = 1'b0;
	logic serial_data_in;
	logic [7:0] rx_fill_level = 8'h00;
	logic serial_data_out;
	logic term_ready_n;
	logic rx_serial;
	logic [7:0] fifo_depth;
	logic [31:0] rd;
	int fail_count = 0;
	int total_checks = 0;

	always #5 aclk = ~aclk;

	uart_pin_ctrl #(.FIFO_WORDS(4)) uart_pin_ctrl_inst (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .fifo_depth_strap(fifo_depth_strap),
		.serial_data_in(serial_data_in), .rx_fill_level(rx_fill_level),
		.serial_data_out(serial_data_out), .term_ready_n(term_ready_n),
		.rx_serial(rx_serial), .fifo_depth(fifo_depth));

	line_partner #(.BIT_CLKS(16 * BAUD)) line_partner_inst (.aclk(aclk),
		.serial_data_out(serial_data_out), .serial_data_in(serial_data_in));

	////////////////////////////////////////////////////////////////////////////////
	// Verdict and comparisons
	task finish_test;
		if (fail_count == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test

	task automatic check32(input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: expected %h got %h", $time, exp, got);
		end
	endtask : check32

	task automatic check_count(input int lo, input int hi, input int got);
		total_checks++;
		if (got < lo || got > hi) begin
			fail_count++;
			$display("Error at %0t: expected %h..%h got %h", $time, lo, hi, got);
		end
	endtask : check_count

	// A wait that runs out is a mismatch and ends the run
	task timeout;
		check32(32'h1, 32'h0);
		finish_test();
	endtask : timeout

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite master; the trailing edge keeps two drives apart in time
	task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_open;
		logic w_open;
		aw_open = 1'b1;
		w_open = 1'b1;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int i = 0; i < 4000; i++) begin
			@(posedge aclk);
			if (!aw_open && !w_open && bvalid === 1'b1) begin
				check32({30'h0, er}, {30'h0, bresp});
				bready <= 1'b0;
				@(posedge aclk);
				return;
			end
			if (aw_open && awready === 1'b1) begin
				aw_open = 1'b0;
				awvalid <= 1'b0;
			end
			if (w_open && wready === 1'b1) begin
				w_open = 1'b0;
				wvalid <= 1'b0;
			end
		end
		timeout();
	endtask : bus_write

	task automatic bus_read(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		logic ar_open;
		ar_open = 1'b1;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int i = 0; i < 200; i++) begin
			@(posedge aclk);
			if (!ar_open && rvalid === 1'b1) begin
				d = rdata;
				check32({30'h0, er}, {30'h0, rresp});
				rready <= 1'b0;
				@(posedge aclk);
				return;
			end
			if (ar_open && arready === 1'b1) begin
				ar_open = 1'b0;
				arvalid <= 1'b0;
			end
		end
		timeout();
	endtask : bus_read

	task automatic wait_pin(input logic v);
		for (int i = 0; i < 200; i++) begin
			@(posedge aclk);
			if (term_ready_n === v) begin
				check32({31'h0, v}, {31'h0, term_ready_n});
				return;
			end
		end
		timeout();
	endtask : wait_pin

	// Poll the transmitter-empty flag; the FIFO hand-off takes a few clocks
	task automatic wait_idle;
		repeat (4) @(posedge aclk);
		for (int i = 0; i < 400; i++) begin
			bus_read(ADDR_STATUS, rd, RESP_OKAY);
			if (rd[ST_TXEMPTY_BIT] === 1'b1) return;
		end
		timeout();
	endtask : wait_idle

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic test_regs;
		bus_read(ADDR_THRESH, rd, RESP_OKAY);
		check32({16'h0, LOWER_RST, UPPER_RST}, rd);
		bus_read(ADDR_BAUD, rd, RESP_OKAY);
		check32({16'h0, BAUD_RST}, rd);
		bus_write(8'h30, 32'hFF, RESP_SLVERR);
		bus_read(8'h30, rd, RESP_SLVERR);
		check32(32'h0, rd);
		bus_write(ADDR_BAUD, BAUD, RESP_OKAY);
		bus_read(ADDR_BAUD, rd, RESP_OKAY);
		check32(BAUD, rd);
	endtask : test_regs

	task automatic test_depth;
		check32(32'h10, {24'h0, fifo_depth});
		bus_read(ADDR_STATUS, rd, RESP_OKAY);
		check32(32'h0, {31'h0, rd[ST_STRAP_BIT]});
		fifo_depth_strap <= 1'b1;
		repeat (8) @(posedge aclk);
		check32(32'h80, {24'h0, fifo_depth});
		bus_read(ADDR_STATUS, rd, RESP_OKAY);
		check32(32'h1, {31'h0, rd[ST_STRAP_BIT]});
		fifo_depth_strap <= 1'b0;
		repeat (8) @(posedge aclk);
		check32(32'h10, {24'h0, fifo_depth});
		bus_write(ADDR_LINECTL, 32'h80, RESP_OKAY);
		bus_write(ADDR_FIFOCTL, 32'h20, RESP_OKAY);
		repeat (2) @(posedge aclk);
		check32(32'h80, {24'h0, fifo_depth});
		bus_write(ADDR_FIFOCTL, 32'h00, RESP_OKAY);
		bus_write(ADDR_LINECTL, 32'h00, RESP_OKAY);
		bus_write(ADDR_CTRL, 32'h1, RESP_OKAY);
		repeat (2) @(posedge aclk);
		check32(32'h80, {24'h0, fifo_depth});
		bus_write(ADDR_CTRL, 32'h0, RESP_OKAY);
		repeat (2) @(posedge aclk);
		check32(32'h10, {24'h0, fifo_depth});
	endtask : test_depth

	task automatic test_plain;
		check32(32'h1, {31'h0, term_ready_n});
		bus_write(ADDR_MODEMCTL, 32'h1, RESP_OKAY);
		wait_pin(1'b0);
		bus_write(ADDR_MODEMCTL, 32'h0, RESP_OKAY);
		wait_pin(1'b1);
	endtask : test_plain

	// Walk the fill level across both thresholds in both directions
	task automatic test_flow;
		logic [7:0] lvl [6] = '{8'h0B, 8'h0C, 8'h05, 8'h04, 8'h03, 8'h0C};
		logic exp [6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
		bus_write(ADDR_CTRL, 32'h2, RESP_OKAY);
		for (int i = 0; i < 6; i++) begin
			rx_fill_level <= lvl[i];
			repeat (3) @(posedge aclk);
			check32({31'h0, exp[i]}, {31'h0, term_ready_n});
		end
		rx_fill_level <= 8'h00;
		bus_write(ADDR_CTRL, 32'h0, RESP_OKAY);
	endtask : test_flow

	task automatic test_485;
		line_partner_inst.frames.delete();
		bus_write(ADDR_MODEMCTL, 32'h1, RESP_OKAY);
		bus_write(ADDR_ADDCTL, 32'h10, RESP_OKAY);
		wait_pin(1'b1);
		bus_write(ADDR_TXDATA, 32'h5A, RESP_OKAY);
		wait_pin(1'b0);
		wait_idle();
		wait_pin(1'b1);
		check32(32'h5A, {24'h0, line_partner_inst.frames.pop_front()});
		bus_write(ADDR_ADDCTL, 32'h18, RESP_OKAY);
		wait_pin(1'b0);
		bus_write(ADDR_ADDCTL, 32'h0, RESP_OKAY);
		bus_write(ADDR_MODEMCTL, 32'h0, RESP_OKAY);
	endtask : test_485

	// Count pin toggles over 128 clocks; one tick is BAUD clocks.
	// The 1x clock only runs while a frame is shifting, so a byte is sent first.
	task automatic test_clock;
		int n;
		logic prev;
		for (int m = 1; m < 3; m++) begin
			bus_write(ADDR_CLKSEL, m << 4, RESP_OKAY);
			if (m == 1) bus_write(ADDR_TXDATA, 32'h5A, RESP_OKAY);
			n = 0;
			prev = term_ready_n;
			for (int i = 0; i < 128; i++) begin
				@(posedge aclk);
				if (term_ready_n !== prev) n++;
				prev = term_ready_n;
			end
			if (m == 1) check_count(7, 9, n);
			else check_count(62, 65, n);
		end
		bus_write(ADDR_CLKSEL, 32'h0, RESP_OKAY);
		wait_idle();
	endtask : test_clock

	// Six writes overrun the four-word buffer; the slow line drains it in order
	task automatic test_fifo;
		line_partner_inst.frames.delete();
		for (int i = 1; i < 7; i++) bus_write(ADDR_TXDATA, i * 32'h11, RESP_OKAY);
		for (int i = 0; i < 8000 && line_partner_inst.frames.size() < 6; i++) @(posedge aclk);
		if (line_partner_inst.frames.size() < 6) timeout();
		for (int i = 1; i < 7; i++)
			check32(i * 32'h11, {24'h0, line_partner_inst.frames.pop_front()});
		wait_idle();
	endtask : test_fifo

	task automatic test_irda;
		int base;
		int low;
		bus_write(ADDR_CTRL, 32'h1, RESP_OKAY);
		line_partner_inst.nrz_on = 1'b0;
		// Idle IrDA input is low; a high line would read as one endless pulse
		line_partner_inst.drive_line(1'b0, 8);
		bus_write(ADDR_MODEMCTL, 32'h40, RESP_OKAY);
		line_partner_inst.drive_line(1'b0, 4);
		check32(32'h0, {31'h0, serial_data_out});
		check32(32'h1, {31'h0, rx_serial});
		base = line_partner_inst.pulse_count;
		bus_write(ADDR_TXDATA, 32'h0F, RESP_OKAY);
		wait_idle();
		check_count(5, 5, line_partner_inst.pulse_count - base);
		low = 0;
		// Pulse and count run side by side so the whole decoded zero is seen
		fork
			begin
				line_partner_inst.drive_line(1'b1, 3 * BAUD);
				line_partner_inst.drive_line(1'b0, 1);
			end
			for (int i = 0; i < 80; i++) begin
				@(posedge aclk);
				if (rx_serial === 1'b0) low++;
			end
		join
		check_count(16 * BAUD - 2, 16 * BAUD + 2, low);
		bus_write(ADDR_MODEMCTL, 32'h0, RESP_OKAY);
		bus_write(ADDR_CTRL, 32'h0, RESP_OKAY);
		line_partner_inst.drive_line(1'b1, 40);
		line_partner_inst.nrz_on = 1'b1;
		line_partner_inst.drive_line(1'b0, 10);
		check32(32'h0, {31'h0, rx_serial});
		line_partner_inst.drive_line(1'b1, 10);
		check32(32'h1, {31'h0, rx_serial});
	endtask : test_irda

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		test_regs();
		test_depth();
		test_plain();
		test_flow();
		test_485();
		test_clock();
		test_fifo();
		test_irda();
		finish_test();
	end
endmodule : test_uart_pin_function_control

`default_nettype wire
